// ===== hdl/spc_pkg.sv
// Shared constants and types for the serial port configuration block
package spc_pkg;
  // Register numbers and the module reset command code
  localparam logic [15:0] SPC_ADDR_SYS_CMD      = 16'h0001;
  localparam logic [15:0] SPC_ADDR_DBG_RATE_SEL = 16'h0012;
  localparam logic [15:0] SPC_ADDR_DBG_FMT      = 16'h0013;
  localparam logic [15:0] SPC_ADDR_DBG_RATE_NOW = 16'h0014;
  localparam logic [15:0] SPC_ADDR_DBG_FMT_NOW  = 16'h0015;
  localparam logic [15:0] SPC_ADDR_SYNC_MODE    = 16'h0016;
  localparam logic [15:0] SPC_ADDR_SYNC_NOW     = 16'h0017;
  localparam logic [15:0] SPC_ADDR_SPI_SEL      = 16'h0018;
  localparam logic [15:0] SPC_ADDR_SPI_NOW      = 16'h0019;
  localparam logic [15:0] SPC_CMD_MODULE_RESET  = 16'h0003;

  // Format field positions
  localparam int SPC_PARITY_ON_BIT      = 0;
  localparam int SPC_ODD_PARITY_SEL_BIT = 1;
  localparam int SPC_TWO_STOP_SEL_BIT   = 2;

  // Reset, fallback and limit values
  localparam logic [7:0] SPC_FMT_RST        = 8'h01;
  localparam logic [7:0] SPC_RATE_RST       = 8'h07;
  localparam logic [7:0] SPC_MODE_RST       = 8'h01;
  localparam logic [7:0] SPC_SPI_RST        = 8'h04;
  localparam logic [7:0] SPC_FALLBACK_RATE  = 8'h07;
  localparam logic [2:0] SPC_FALLBACK_FMT   = 3'h1;
  localparam logic [7:0] SPC_FMT_MAX        = 8'h07;
  localparam logic [7:0] SPC_RATE_MIN       = 8'h01;
  localparam logic [7:0] SPC_RATE_MAX       = 8'h07;

  // Synchronous port modes
  localparam logic [7:0] SPC_MODE_OFF       = 8'h00;
  localparam logic [7:0] SPC_MODE_SHIFT_AUT = 8'h01;
  localparam logic [7:0] SPC_MODE_SHIFT_MAN = 8'h02;
  localparam logic [7:0] SPC_MODE_SPI_SLAVE = 8'h03;
  localparam logic [7:0] SPC_MODE_SHIFT_ERR = 8'h04;

  // SPI clock and phase codes
  localparam logic [7:0] SPC_SPI_OFF        = 8'h00;
  localparam logic [7:0] SPC_SPI_MIN        = 8'h01;
  localparam logic [7:0] SPC_SPI_MAX        = 8'h04;
  localparam logic [7:0] SPC_SPI_MASTER     = 8'h04;

  // Timing
  localparam int unsigned SPC_CLK_HZ   = 200_000_000;
  localparam int unsigned SPC_BAUD_1   = 2400;
  localparam int unsigned SPC_BAUD_2   = 4800;
  localparam int unsigned SPC_BAUD_3   = 9600;
  localparam int unsigned SPC_BAUD_4   = 19200;
  localparam int unsigned SPC_BAUD_5   = 38400;
  localparam int unsigned SPC_BAUD_6   = 57600;
  localparam int unsigned SPC_BAUD_7   = 115200;
  localparam int          SPC_DIV_W    = 17;
  localparam logic [2:0]  SPC_LAST_BIT = 3'h7;

  typedef enum logic [2:0] {
    SPC_TX_IDLE   = 3'b000,
    SPC_TX_START  = 3'b001,
    SPC_TX_DATA   = 3'b011,
    SPC_TX_PARITY = 3'b010,
    SPC_TX_STOP   = 3'b110
  } spc_tx_state_t;
endpackage

// ===== hdl/spc_serial_port_config_regs.sv
// Configuration registers for the debug and synchronous serial ports
// Operation
// R1: Debug bitrate always from explicit setting
// R2: Invalid debug setup falls back to 115200 8E1
// R3: Format bit 0 enables parity
// R4: Format bit 1 odd parity, ignored without parity
// R5: Format bit 2 selects two stop bits
// R6: Format readback shows format in use
// R7: Bitrate readback codes 1 to 7
// R8: Settings apply after module reset command
// R9: Sync mode accepts codes 0 to 3
// R10: Sync readback shows 4 on shift error
// R11: SPI selection used only in SPI slave
// R12: Shift master forces lagging edge, idle high
// R13: SPI codes 1 to 4 select CPHA/CPOL
// R14: SPI readback zero when port disabled
// R15: Debug frame start, 8 LSB-first, parity, stops
`timescale 1ns/10ps
module spc_serial_port_config_regs #(
  parameter int unsigned CLK_FREQ_HZ = spc_pkg::SPC_CLK_HZ
) (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [15:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic             reg_rvalid,
  input  wire logic        shift_chain_error,
  input  wire logic [7:0]  tx_data,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  output logic             debug_port_txd,
  output logic [7:0]       sync_mode_active,
  output logic             spi_cpol,
  output logic             spi_cpha,
  output logic             spi_msb_first
);
  import spc_pkg::*;

  logic [7:0]            fmt_cfg_reg;
  logic [7:0]            rate_cfg_reg;
  logic [7:0]            mode_cfg_reg;
  logic [7:0]            spi_cfg_reg;
  logic [2:0]            fmt_act_reg;
  logic [7:0]            rate_act_reg;
  logic [7:0]            spi_act_reg;
  logic [SPC_DIV_W-1:0]  bit_len_reg;
  logic                  apply;
  logic                  cfg_bad;
  logic [7:0]            rate_next;
  logic [2:0]            fmt_next;
  logic [7:0]            mode_now;
  logic [7:0]            spi_now;
  logic [15:0]           rdata_next;

  // Each case divides by a constant so no runtime divider is built
  function automatic logic [SPC_DIV_W-1:0] bit_cycles(input logic [7:0] code);
    int unsigned d;
    d = CLK_FREQ_HZ / SPC_BAUD_7;
    unique case (code)
      8'h01:   d = CLK_FREQ_HZ / SPC_BAUD_1;
      8'h02:   d = CLK_FREQ_HZ / SPC_BAUD_2;
      8'h03:   d = CLK_FREQ_HZ / SPC_BAUD_3;
      8'h04:   d = CLK_FREQ_HZ / SPC_BAUD_4;
      8'h05:   d = CLK_FREQ_HZ / SPC_BAUD_5;
      8'h06:   d = CLK_FREQ_HZ / SPC_BAUD_6;
      default: d = CLK_FREQ_HZ / SPC_BAUD_7;
    endcase
    if (d < 2) begin
      d = 2;
    end
    return SPC_DIV_W'(d - 1);
  endfunction

  assign apply = reg_wr && (reg_addr == SPC_ADDR_SYS_CMD)
                 && (reg_wdata == SPC_CMD_MODULE_RESET); // R8

  // No automatic detection: code zero is just another invalid setting
  assign cfg_bad = (rate_cfg_reg < SPC_RATE_MIN) || (rate_cfg_reg > SPC_RATE_MAX)
                   || (fmt_cfg_reg > SPC_FMT_MAX); // R1
  assign rate_next = cfg_bad ? SPC_FALLBACK_RATE : rate_cfg_reg; // R2
  assign fmt_next  = cfg_bad ? SPC_FALLBACK_FMT : fmt_cfg_reg[2:0]; // R2

  // Stored settings, written by the master
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      fmt_cfg_reg  <= SPC_FMT_RST;
      rate_cfg_reg <= SPC_RATE_RST;
      mode_cfg_reg <= SPC_MODE_RST;
      spi_cfg_reg  <= SPC_SPI_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        SPC_ADDR_DBG_FMT:      fmt_cfg_reg  <= reg_wdata[7:0];
        SPC_ADDR_DBG_RATE_SEL: rate_cfg_reg <= reg_wdata[7:0];
        SPC_ADDR_SYNC_MODE: begin
          if (reg_wdata <= 16'(SPC_MODE_SPI_SLAVE)) begin
            mode_cfg_reg <= reg_wdata[7:0]; // R9
          end
        end
        SPC_ADDR_SPI_SEL: begin
          if (reg_wdata >= 16'(SPC_SPI_MIN) && reg_wdata <= 16'(SPC_SPI_MAX)) begin
            spi_cfg_reg <= reg_wdata[7:0]; // R13
          end
        end
        default: ;
      endcase
    end
  end

  // Active settings change only on the module reset command
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      fmt_act_reg      <= SPC_FMT_RST[2:0];
      rate_act_reg     <= SPC_RATE_RST;
      sync_mode_active <= SPC_MODE_RST;
      spi_act_reg      <= SPC_SPI_RST;
    end else if (apply) begin
      fmt_act_reg      <= fmt_next; // R8
      rate_act_reg     <= rate_next; // R8
      sync_mode_active <= mode_cfg_reg; // R8
      spi_act_reg      <= spi_cfg_reg; // R8
    end
  end

  // Bit time follows the active rate only, never a detected one
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      bit_len_reg <= bit_cycles(SPC_RATE_RST);
    end else if (apply) begin
      bit_len_reg <= bit_cycles(rate_next); // R1
    end
  end

  always_comb begin
    mode_now = sync_mode_active;
    if ((sync_mode_active == SPC_MODE_SHIFT_AUT || sync_mode_active == SPC_MODE_SHIFT_MAN)
        && shift_chain_error) begin
      mode_now = SPC_MODE_SHIFT_ERR; // R10
    end
  end

  always_comb begin
    unique case (sync_mode_active)
      SPC_MODE_OFF:       spi_now = SPC_SPI_OFF; // R14
      SPC_MODE_SPI_SLAVE: spi_now = spi_act_reg; // R11
      default:            spi_now = SPC_SPI_MASTER; // R12
    endcase
  end

  // SPI pins: codes 3 and 4 lag, codes 2 and 4 idle high
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      spi_cpol      <= 1'b1;
      spi_cpha      <= 1'b1;
      spi_msb_first <= 1'b1;
    end else begin
      spi_cpha      <= (spi_now == 8'h03) || (spi_now == 8'h04); // R13
      spi_cpol      <= (spi_now == 8'h02) || (spi_now == 8'h04); // R13
      spi_msb_first <= 1'b1; // R13
    end
  end

  always_comb begin
    rdata_next = 16'h0000;
    unique case (reg_addr)
      SPC_ADDR_DBG_RATE_SEL: rdata_next = {8'h00, rate_cfg_reg};
      SPC_ADDR_DBG_FMT:      rdata_next = {8'h00, fmt_cfg_reg};
      SPC_ADDR_DBG_RATE_NOW: rdata_next = {8'h00, rate_act_reg}; // R7
      SPC_ADDR_DBG_FMT_NOW:  rdata_next = {13'h0000, fmt_act_reg}; // R6
      SPC_ADDR_SYNC_MODE:    rdata_next = {8'h00, mode_cfg_reg};
      SPC_ADDR_SYNC_NOW:     rdata_next = {8'h00, mode_now}; // R10
      SPC_ADDR_SPI_SEL:      rdata_next = {8'h00, spi_cfg_reg};
      SPC_ADDR_SPI_NOW:      rdata_next = {8'h00, spi_now}; // R14
      default:               rdata_next = 16'h0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_next;
      end
    end
  end

  // Debug port transmitter
  spc_tx_state_t        tx_state_reg;
  logic [SPC_DIV_W-1:0] tick_cnt_reg;
  logic [2:0]           bit_idx_reg;
  logic [7:0]           shift_reg;
  logic                 par_on_reg;
  logic                 par_odd_reg;
  logic                 two_stop_reg;
  logic                 stop_idx_reg;
  logic                 par_bit_reg;
  logic                 bit_end;
  logic                 accept;
  logic                 data_last;
  logic                 stop_more;

  assign bit_end   = (tick_cnt_reg == '0);
  assign accept    = (tx_state_reg == SPC_TX_IDLE) && tx_valid && tx_ready;
  assign data_last = (bit_idx_reg == SPC_LAST_BIT);
  assign stop_more = two_stop_reg && !stop_idx_reg;

  // Bit timer restarts when a character is taken and at every bit boundary
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tick_cnt_reg <= '0;
    end else if (accept || bit_end) begin
      tick_cnt_reg <= bit_len_reg;
    end else begin
      tick_cnt_reg <= tick_cnt_reg - 1'b1;
    end
  end

  // Frame sequencer
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tx_state_reg <= SPC_TX_IDLE;
    end else begin
      unique case (tx_state_reg)
        SPC_TX_IDLE: begin
          if (accept) begin
            tx_state_reg <= SPC_TX_START;
          end
        end
        SPC_TX_START: begin
          if (bit_end) begin
            tx_state_reg <= SPC_TX_DATA;
          end
        end
        SPC_TX_DATA: begin
          if (bit_end && data_last) begin
            tx_state_reg <= par_on_reg ? SPC_TX_PARITY : SPC_TX_STOP; // R3
          end
        end
        SPC_TX_PARITY: begin
          if (bit_end) begin
            tx_state_reg <= SPC_TX_STOP;
          end
        end
        SPC_TX_STOP: begin
          if (bit_end && !stop_more) begin
            tx_state_reg <= SPC_TX_IDLE; // R5
          end
        end
      endcase
    end
  end

  // Data bits leave from the low end of the shifter
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      bit_idx_reg <= 3'h0;
      shift_reg   <= 8'h00;
    end else if (accept) begin
      shift_reg   <= tx_data;
    end else if (bit_end) begin
      if (tx_state_reg == SPC_TX_START) begin
        bit_idx_reg <= 3'h0;
      end else if (tx_state_reg == SPC_TX_DATA && !data_last) begin
        shift_reg   <= {1'b0, shift_reg[7:1]};
        bit_idx_reg <= bit_idx_reg + 3'h1;
      end
    end
  end

  // Format is latched per character; the bit time is not, so apply between characters
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      par_on_reg   <= 1'b0;
      par_odd_reg  <= 1'b0;
      two_stop_reg <= 1'b0;
      par_bit_reg  <= 1'b0;
    end else if (accept) begin
      par_on_reg   <= fmt_act_reg[SPC_PARITY_ON_BIT]; // R3
      par_odd_reg  <= fmt_act_reg[SPC_ODD_PARITY_SEL_BIT]; // R4
      two_stop_reg <= fmt_act_reg[SPC_TWO_STOP_SEL_BIT]; // R5
      par_bit_reg  <= ^tx_data;
    end
  end

  // Second stop bit is counted here
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      stop_idx_reg <= 1'b0;
    end else if (tx_state_reg == SPC_TX_DATA && bit_end && data_last) begin
      stop_idx_reg <= 1'b0;
    end else if (tx_state_reg == SPC_TX_STOP && bit_end && stop_more) begin
      stop_idx_reg <= 1'b1; // R5
    end
  end

  // Stop bits and the idle line are both high
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      debug_port_txd <= 1'b1;
    end else begin
      unique case (tx_state_reg)
        SPC_TX_IDLE: begin
          debug_port_txd <= accept ? 1'b0 : 1'b1; // R15
        end
        SPC_TX_START: begin
          if (bit_end) begin
            debug_port_txd <= shift_reg[0]; // R15
          end
        end
        SPC_TX_DATA: begin
          if (bit_end) begin
            if (!data_last) begin
              debug_port_txd <= shift_reg[1]; // R15
            end else if (par_on_reg) begin
              debug_port_txd <= par_bit_reg ^ par_odd_reg; // R4
            end else begin
              debug_port_txd <= 1'b1;
            end
          end
        end
        SPC_TX_PARITY: begin
          if (bit_end) begin
            debug_port_txd <= 1'b1;
          end
        end
        SPC_TX_STOP: begin
          debug_port_txd <= 1'b1;
        end
      endcase
    end
  end

  // Ready returns with the end of the last stop bit
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      tx_ready <= 1'b0;
    end else if (accept) begin
      tx_ready <= 1'b0;
    end else if (tx_state_reg == SPC_TX_IDLE) begin
      tx_ready <= 1'b1;
    end else if (tx_state_reg == SPC_TX_STOP && bit_end && !stop_more) begin
      tx_ready <= 1'b1; // R5
    end
  end
endmodule

// ===== sim/spc_cfg_props.sv
// Concurrent checks on the ports of the serial port configuration block
`timescale 1ns/10ps
module spc_cfg_props (
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       reg_rd,
  input wire logic       reg_rvalid,
  input wire logic       tx_valid,
  input wire logic       tx_ready,
  input wire logic       debug_port_txd,
  input wire logic [7:0] sync_mode_active,
  input wire logic       spi_cpol,
  input wire logic       spi_cpha,
  input wire logic       spi_msb_first
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_accept;
    tx_valid && tx_ready;
  endsequence
  sequence s_shift_mode;
    sync_mode_active == 8'h01 || sync_mode_active == 8'h02;
  endsequence
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe not answered");
  a_read_single: assert property (!reg_rd |=> !reg_rvalid)
    else $error("read valid without a read");
  a_mode_range: assert property (sync_mode_active <= 8'h03)
    else $error("active mode code out of range");
  a_master_clock: assert property (s_shift_mode |=> spi_cpol && spi_cpha && spi_msb_first)
    else $error("shift master clock setting wrong");
  a_slave_order: assert property (sync_mode_active == 8'h03 |=> spi_msb_first)
    else $error("slave not msb first");
  a_spi_off: assert property (sync_mode_active == 8'h00 |=> !spi_cpol && !spi_cpha)
    else $error("disabled port clock setting wrong");
  a_start_bit: assert property (s_accept |=> !tx_ready && !debug_port_txd)
    else $error("no start bit after accept");
  a_frame_busy: assert property (s_accept |=> !tx_ready [*8])
    else $error("ready during frame");
  a_idle_high: assert property (tx_ready |-> debug_port_txd)
    else $error("line not idle high");
endmodule
bind spc_serial_port_config_regs spc_cfg_props u_spc_cfg_props (
  .core_clk(core_clk), .nrst(nrst), .reg_rd(reg_rd), .reg_rvalid(reg_rvalid),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .debug_port_txd(debug_port_txd),
  .sync_mode_active(sync_mode_active), .spi_cpol(spi_cpol), .spi_cpha(spi_cpha),
  .spi_msb_first(spi_msb_first));

// ===== sim/spc_master.sv
// Register bus master model that writes and reads configuration words
`timescale 1ns/10ps
module spc_master (
  input  wire logic        core_clk,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid,
  output logic      [15:0] reg_addr,
  output logic             reg_wr,
  output logic      [15:0] reg_wdata,
  output logic             reg_rd
);
  import spc_pkg::*;
  initial begin
    reg_addr = 16'h0000;
    reg_wr = 1'b0;
    reg_wdata = 16'h0000;
    reg_rd = 1'b0;
  end
  // Lines are inverted when released so a stale value never passes for a request
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic ok);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
    ok = reg_rvalid;
  endtask
  // Settings only take hold through the module reset command
  task automatic apply;
    wr(SPC_ADDR_SYS_CMD, SPC_CMD_MODULE_RESET);
  endtask
endmodule

// ===== sim/test_serial_port_config_regs.sv
// Self-checking bench for the serial port configuration block
`timescale 1ns/10ps
module test_serial_port_config_regs;
  import spc_pkg::*;
  localparam int BITN = 10;
  typedef struct packed {
    logic [7:0]  waddr;
    logic [15:0] wdata;
    logic        app;
    logic [7:0]  raddr;
    logic [15:0] exp;
  } spc_row_t;
  localparam spc_row_t ROWS [19] = '{
    '{8'h40, 16'h0000, 1'b0, 8'h13, 16'h0001}, '{8'h40, 16'h0000, 1'b0, 8'h16, 16'h0001},
    '{8'h40, 16'h0000, 1'b0, 8'h18, 16'h0004}, '{8'h40, 16'h0000, 1'b0, 8'h19, 16'h0004},
    '{8'h40, 16'h0000, 1'b0, 8'h14, 16'h0007}, '{8'h13, 16'h0005, 1'b0, 8'h15, 16'h0001},
    '{8'h13, 16'h0005, 1'b1, 8'h15, 16'h0005}, '{8'h12, 16'h0003, 1'b1, 8'h14, 16'h0003},
    '{8'h12, 16'h0000, 1'b1, 8'h14, 16'h0007}, '{8'h12, 16'h0003, 1'b1, 8'h15, 16'h0005},
    '{8'h13, 16'h0008, 1'b1, 8'h15, 16'h0001},
    '{8'h16, 16'h0003, 1'b1, 8'h17, 16'h0003}, '{8'h18, 16'h0002, 1'b1, 8'h19, 16'h0002},
    '{8'h18, 16'h0007, 1'b0, 8'h18, 16'h0002}, '{8'h16, 16'h0005, 1'b0, 8'h16, 16'h0003},
    '{8'h17, 16'h0002, 1'b0, 8'h17, 16'h0003}, '{8'h16, 16'h0000, 1'b1, 8'h19, 16'h0000},
    '{8'h40, 16'h0009, 1'b0, 8'h40, 16'h0000}, '{8'h12, 16'h0007, 1'b0, 8'h12, 16'h0007}};
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, rdat;
  logic        reg_wr, reg_rd, reg_rvalid, ok, tx_ready, debug_port_txd;
  logic        shift_chain_error = 1'b0;
  logic [7:0]  tx_data = 8'h00;
  logic        tx_valid = 1'b0;
  logic [7:0]  sync_mode_active;
  logic        spi_cpol, spi_cpha, spi_msb_first;
  logic        b [12];
  int          mismatches = 0;
  int          samples_checked = 0;
  int          n;
  always #2.5 core_clk = ~core_clk;
  spc_serial_port_config_regs #(.CLK_FREQ_HZ(1_152_000)) u_spc_serial_port_config_regs (
    .core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .shift_chain_error(shift_chain_error), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .debug_port_txd(debug_port_txd), .sync_mode_active(sync_mode_active),
    .spi_cpol(spi_cpol), .spi_cpha(spi_cpha), .spi_msb_first(spi_msb_first));
  spc_master u_spc_master (.core_clk(core_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd));
  task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    u_spc_master.rd({8'h00, a}, rdat, ok);
    chk({ok, rdat}, {1'b1, e});
  endtask
  task automatic results;
    $display("checks=%0d mismatches=%0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Sends one character and samples every bit in its centre
  task automatic send(input logic [7:0] f, input logic [7:0] d);
    u_spc_master.wr(SPC_ADDR_DBG_FMT, {8'h00, f});
    u_spc_master.apply();
    b[0] = 1'b0;
    for (int i = 0; i < 8; i++) b[i + 1] = d[i];
    n = 9;
    if (f[0]) begin
      b[n] = ^d ^ f[1];
      n = n + 1;
    end
    b[n] = 1'b1;
    n = n + 1;
    if (f[2]) begin
      b[n] = 1'b1;
      n = n + 1;
    end
    for (int k = 0; k < 200 && tx_ready !== 1'b1; k++) @(negedge core_clk);
    tx_data = d;
    tx_valid = 1'b1;
    @(negedge core_clk);
    tx_valid = 1'b0;
    repeat (BITN / 2) @(negedge core_clk);
    for (int i = 0; i < n; i++) begin
      chk({15'h0000, debug_port_txd, tx_ready}, {15'h0000, b[i], 1'b0});
      repeat (BITN) @(negedge core_clk);
    end
    chk({15'h0000, debug_port_txd, tx_ready}, 17'h0_0003);
  endtask
  initial begin
    #100_000;
    mismatches++;
    results();
  end
  initial begin
    repeat (3) @(negedge core_clk);
    nrst = 1'b1;
    foreach (ROWS[i]) begin
      u_spc_master.wr({8'h00, ROWS[i].waddr}, ROWS[i].wdata);
      if (ROWS[i].app) u_spc_master.apply();
      rchk(ROWS[i].raddr, ROWS[i].exp);
    end
    u_spc_master.wr(SPC_ADDR_SYNC_MODE, 16'h0002);
    u_spc_master.apply();
    shift_chain_error = 1'b1;
    rchk(8'h19, 16'h0004);
    rchk(8'h17, 16'h0004);
    chk(17'({spi_cpol, spi_cpha, spi_msb_first}), 17'h0_0007);
    chk(17'(sync_mode_active), 17'(SPC_MODE_SHIFT_MAN));
    shift_chain_error = 1'b0;
    rchk(8'h17, 16'h0002);
    u_spc_master.wr(SPC_ADDR_SYNC_MODE, 16'h0003);
    for (int c = 1; c <= 4; c++) begin
      u_spc_master.wr(SPC_ADDR_SPI_SEL, 16'(c));
      u_spc_master.apply();
      @(negedge core_clk);
      chk(17'({spi_cpol, spi_cpha, spi_msb_first}), 17'({~c[0], c > 2, 1'b1}));
    end
    send(8'h07, 8'hA5);
    send(8'h01, 8'h81);
    send(8'h02, 8'h3C);
    @(negedge core_clk);
    nrst = 1'b0;
    @(negedge core_clk);
    nrst = 1'b1;
    rchk(8'h13, 16'h0001);
    rchk(8'h17, 16'h0001);
    chk(17'(sync_mode_active), 17'h0_0001);
    results();
  end
endmodule
